// ===== core/sel_pkg.sv
// package of register map, field layout and reset values for the sram error log block
package sel_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ECC_LOG      = 8'h00;
  localparam logic [7:0] OFF_ECC_ADDR     = 8'h04;
  localparam logic [7:0] OFF_ECC_CTX      = 8'h08;
  localparam logic [7:0] OFF_ECC_TEST     = 8'h0C;
  localparam logic [7:0] OFF_ECC_CTRL     = 8'h10;
  localparam logic [7:0] OFF_PAR_CSR      = 8'h14;
  localparam logic [7:0] OFF_PAR_ADDR_LO  = 8'h18;
  localparam logic [7:0] OFF_PAR_ADDR_HI  = 8'h1C;
  localparam logic [7:0] OFF_PAR_CTX_LO   = 8'h20;
  localparam logic [7:0] OFF_PAR_CTX_HI   = 8'h24;
  localparam logic [7:0] OFF_INT_STATUS   = 8'h28;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int ECC_LOG_SYN_LSB  = 0;
  localparam int ECC_LOG_TYPE_BIT = 8;
  localparam int ECC_LOG_RW_BIT   = 12;
  localparam int ECC_CTRL_UA_LSB  = 0;
  localparam int PAR_CSR_EN_BIT   = 0;
  localparam int PAR_CSR_TYPE_LSB = 4;
  localparam int ST_ECC_FIRST     = 0;
  localparam int ST_ECC_MULTI     = 1;
  localparam int ST_PAR_FIRST     = 8;
  localparam int ST_PAR_MULTI     = 9;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int SYN_W     = 8;
  localparam int CHK_W     = 8;
  localparam int ADDR_W    = 36;
  localparam int TAG_W     = 32;
  localparam int PTYPE_W   = 4;
  localparam int UPPER_W   = 4;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : sel_pkg

// ===== core/sel_ecc_mask.sv
// check-bit corruption stage applied to memory writes under the test mask
module sel_ecc_mask (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rstn,
  // write path
  input  wire logic                      wr_valid,
  input  wire logic [sel_pkg::CHK_W-1:0] chk_in,
  input  wire logic [sel_pkg::CHK_W-1:0] mask,
  // to the array
  output logic                           wr_valid_ff,
  output logic [sel_pkg::CHK_W-1:0]      chk_out_ff
);

  // ----------------------------------------------------------------
  // masked check bits
  // ----------------------------------------------------------------
  // mask check bits
  wire logic [sel_pkg::CHK_W-1:0] nxt_chk = chk_in ^ mask;

  // registered so the array sees one clean cycle of latency
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_valid_ff <= 1'b0;
      chk_out_ff  <= '0;
    end else begin
      wr_valid_ff <= wr_valid;
      chk_out_ff  <= nxt_chk;
    end
  end

endmodule : sel_ecc_mask

// ===== core/sel_error_log.sv
// sram ecc and parity error log with test mask, axi4-lite slave
module sel_error_log (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // axi4-lite write address
  input  wire logic                        s_awvalid,
  output logic                             s_awready,
  input  wire logic [7:0]                  s_awaddr,
  // axi4-lite write data
  input  wire logic                        s_wvalid,
  output logic                             s_wready,
  input  wire logic [31:0]                 s_wdata,
  input  wire logic [3:0]                  s_wstrb,
  // axi4-lite write response
  output logic                             s_bvalid,
  input  wire logic                        s_bready,
  output logic [1:0]                       s_bresp,
  // axi4-lite read address
  input  wire logic                        s_arvalid,
  output logic                             s_arready,
  input  wire logic [7:0]                  s_araddr,
  // axi4-lite read data
  output logic                             s_rvalid,
  input  wire logic                        s_rready,
  output logic [31:0]                      s_rdata,
  output logic [1:0]                       s_rresp,
  // ecc error report from the checker
  input  wire logic                        ecc_err,
  input  wire logic                        ecc_multi,
  input  wire logic                        ecc_is_write,
  input  wire logic [sel_pkg::SYN_W-1:0]   ecc_syndrome,
  input  wire logic [sel_pkg::ADDR_W-1:0]  ecc_addr,
  input  wire logic [sel_pkg::TAG_W-1:0]   desc_tag,
  // parity error report from the memory ports
  input  wire logic                        par_err,
  input  wire logic [sel_pkg::PTYPE_W-1:0] par_type,
  input  wire logic [sel_pkg::ADDR_W-1:0]  par_addr,
  input  wire logic [sel_pkg::ADDR_W-1:0]  par_ctx_addr,
  // array write path
  input  wire logic                        mem_wr,
  input  wire logic [sel_pkg::CHK_W-1:0]   mem_chk,
  output logic                             mem_wr_ff,
  output logic [sel_pkg::CHK_W-1:0]        mem_chk_ff,
  // parity settings toward the port checkers
  output logic                             par_check_en_ff,
  output logic [31:0]                      par_cfg_ff,
  // status flags
  output logic [3:0]                       err_flags_ff
);

  // ----------------------------------------------------------------
  // log and control state
  // ----------------------------------------------------------------
  logic [sel_pkg::SYN_W-1:0]   syn_ff;
  logic                        etype_ff;
  logic                        erw_ff;
  logic [31:0]                 eaddr_ff;
  logic [sel_pkg::UPPER_W-1:0] eupper_ff;
  logic [sel_pkg::TAG_W-1:0]   etag_ff;
  logic [sel_pkg::CHK_W-1:0]   tmask_ff;
  logic [sel_pkg::PTYPE_W-1:0] ptype_ff;
  logic [31:0]                 paddr_lo_ff;
  logic [sel_pkg::UPPER_W-1:0] paddr_hi_ff;
  logic [31:0]                 pctx_lo_ff;
  logic [sel_pkg::UPPER_W-1:0] pctx_hi_ff;
  logic                        ecc_first_ff;
  logic                        ecc_multi_ff;
  logic                        par_first_ff;
  logic                        par_multi_ff;
  logic [7:0]                  awaddr_ff;
  logic [31:0]                 wdata_ff;
  logic [3:0]                  wstrb_ff;
  logic                        aw_have_ff;
  logic                        w_have_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic known_off(input logic [7:0] a);
    known_off = (a == sel_pkg::OFF_ECC_LOG)     || (a == sel_pkg::OFF_ECC_ADDR)    ||
                (a == sel_pkg::OFF_ECC_CTX)     || (a == sel_pkg::OFF_ECC_TEST)    ||
                (a == sel_pkg::OFF_ECC_CTRL)    || (a == sel_pkg::OFF_PAR_CSR)     ||
                (a == sel_pkg::OFF_PAR_ADDR_LO) || (a == sel_pkg::OFF_PAR_ADDR_HI) ||
                (a == sel_pkg::OFF_PAR_CTX_LO)  || (a == sel_pkg::OFF_PAR_CTX_HI)  ||
                (a == sel_pkg::OFF_INT_STATUS);
  endfunction : known_off

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // write fires once both halves are held and no response is pending
  wire logic aw_take  = s_awvalid && s_awready;
  wire logic w_take   = s_wvalid && s_wready;
  wire logic wr_go    = aw_have_ff && w_have_ff && !s_bvalid;
  wire logic wr_test  = wr_go && (awaddr_ff == sel_pkg::OFF_ECC_TEST);
  wire logic wr_pcsr  = wr_go && (awaddr_ff == sel_pkg::OFF_PAR_CSR);
  wire logic wr_stat  = wr_go && (awaddr_ff == sel_pkg::OFF_INT_STATUS);
  wire logic rd_take  = s_arvalid && s_arready;
  // status is write-one-to-clear on the flag bits; byte strobes limit which bits clear
  wire logic [31:0] stat_clr = wr_stat ? merge(sel_pkg::ZERO_WORD, wdata_ff, wstrb_ff)
                                       : sel_pkg::ZERO_WORD;

  // ----------------------------------------------------------------
  // capture decisions
  // ----------------------------------------------------------------
  // gate on first flag
  wire logic ecc_log  = ecc_err && !ecc_first_ff;
  wire logic ecc_more = ecc_err && ecc_first_ff;
  wire logic par_seen = par_err && par_check_en_ff;
  wire logic par_log  = par_seen && !par_first_ff;
  wire logic par_more = par_seen && par_first_ff;

  // set wins over a same-cycle clear
  wire logic nxt_ecc_first = ecc_log  || (ecc_first_ff && !stat_clr[sel_pkg::ST_ECC_FIRST]);
  wire logic nxt_ecc_multi = ecc_more || (ecc_multi_ff && !stat_clr[sel_pkg::ST_ECC_MULTI]);
  wire logic nxt_par_first = par_log  || (par_first_ff && !stat_clr[sel_pkg::ST_PAR_FIRST]);
  wire logic nxt_par_multi = par_more || (par_multi_ff && !stat_clr[sel_pkg::ST_PAR_MULTI]);

  // ----------------------------------------------------------------
  // read data assembly
  // ----------------------------------------------------------------
  wire logic [31:0] ecc_log_word = ({31'h0, erw_ff} << sel_pkg::ECC_LOG_RW_BIT) |
                                   ({31'h0, etype_ff} << sel_pkg::ECC_LOG_TYPE_BIT) |
                                   {24'h0, syn_ff};
  wire logic [31:0] par_csr_word = {par_cfg_ff[31:8], ptype_ff, par_cfg_ff[3:1], par_check_en_ff};
  wire logic [31:0] stat_word    = {22'h0, par_multi_ff, par_first_ff, 6'h0,
                                    ecc_multi_ff, ecc_first_ff};
  wire logic [31:0] rd_word =
    (s_araddr == sel_pkg::OFF_ECC_LOG)     ? ecc_log_word :
    (s_araddr == sel_pkg::OFF_ECC_ADDR)    ? eaddr_ff :
    (s_araddr == sel_pkg::OFF_ECC_CTX)     ? etag_ff :
    (s_araddr == sel_pkg::OFF_ECC_TEST)    ? {24'h0, tmask_ff} :
    (s_araddr == sel_pkg::OFF_ECC_CTRL)    ? {28'h0, eupper_ff} :
    (s_araddr == sel_pkg::OFF_PAR_CSR)     ? par_csr_word :
    (s_araddr == sel_pkg::OFF_PAR_ADDR_LO) ? paddr_lo_ff :
    (s_araddr == sel_pkg::OFF_PAR_ADDR_HI) ? {28'h0, paddr_hi_ff} :
    (s_araddr == sel_pkg::OFF_PAR_CTX_LO)  ? pctx_lo_ff :
    (s_araddr == sel_pkg::OFF_PAR_CTX_HI)  ? {28'h0, pctx_hi_ff} :
    (s_araddr == sel_pkg::OFF_INT_STATUS)  ? stat_word : sel_pkg::ZERO_WORD;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // each half is held until the pair is complete
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_awaddr;
      end else if (wr_go) begin
        aw_have_ff <= 1'b0;
      end
      if (w_take) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_wdata;
        wstrb_ff  <= s_wstrb;
      end else if (wr_go) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  // ready only while the slot is empty
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'h0;
    end else begin
      s_awready <= !aw_have_ff && !aw_take && !s_awready;
      s_wready  <= !w_have_ff && !w_take && !s_wready;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= known_off(awaddr_ff) ? sel_pkg::RESP_OKAY : sel_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= 2'h0;
    end else begin
      s_arready <= !s_rvalid && !rd_take && !s_arready;
      if (rd_take) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_word;
        s_rresp  <= known_off(s_araddr) ? sel_pkg::RESP_OKAY : sel_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software-written settings
  // ----------------------------------------------------------------
  // merged words are formed first, since a function result cannot be sliced in place
  wire logic [31:0] nxt_test_word = merge({24'h0, tmask_ff}, wdata_ff, wstrb_ff);
  wire logic [31:0] nxt_pcsr_word = merge(par_csr_word, wdata_ff, wstrb_ff);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tmask_ff        <= '0;
      par_check_en_ff <= 1'b0;
      par_cfg_ff      <= 32'h0000_0000;
    end else begin
      if (wr_test) begin
        tmask_ff <= nxt_test_word[sel_pkg::CHK_W-1:0];
      end
      if (wr_pcsr) begin
        par_check_en_ff <= nxt_pcsr_word[sel_pkg::PAR_CSR_EN_BIT];
        par_cfg_ff      <= nxt_pcsr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // ecc capture
  // ----------------------------------------------------------------
  // hold until first flag cleared
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syn_ff    <= '0;
      etype_ff  <= 1'b0;
      erw_ff    <= 1'b0;
      eaddr_ff  <= 32'h0000_0000;
      eupper_ff <= '0;
      etag_ff   <= '0;
    end else if (ecc_log) begin
      syn_ff    <= ecc_syndrome;
      etype_ff  <= ecc_multi;
      erw_ff    <= ecc_is_write;
      eaddr_ff  <= ecc_addr[31:0];
      eupper_ff <= ecc_addr[sel_pkg::ADDR_W-1:32];
      etag_ff   <= desc_tag;
    end
  end

  // ----------------------------------------------------------------
  // parity capture
  // ----------------------------------------------------------------
  // address pairs belong to the logged type
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ptype_ff    <= '0;
      paddr_lo_ff <= 32'h0000_0000;
      paddr_hi_ff <= '0;
      pctx_lo_ff  <= 32'h0000_0000;
      pctx_hi_ff  <= '0;
    end else if (par_log) begin
      ptype_ff    <= par_type;
      paddr_lo_ff <= par_addr[31:0];
      paddr_hi_ff <= par_addr[sel_pkg::ADDR_W-1:32];
      pctx_lo_ff  <= par_ctx_addr[31:0];
      pctx_hi_ff  <= par_ctx_addr[sel_pkg::ADDR_W-1:32];
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ecc_first_ff <= 1'b0;
      ecc_multi_ff <= 1'b0;
      par_first_ff <= 1'b0;
      par_multi_ff <= 1'b0;
      err_flags_ff <= 4'h0;
    end else begin
      ecc_first_ff <= nxt_ecc_first;
      ecc_multi_ff <= nxt_ecc_multi;
      par_first_ff <= nxt_par_first;
      par_multi_ff <= nxt_par_multi;
      err_flags_ff <= {nxt_par_multi, nxt_par_first, nxt_ecc_multi, nxt_ecc_first};
    end
  end

  // ----------------------------------------------------------------
  // check-bit masking toward the array
  // ----------------------------------------------------------------
  // corrupted check bits make later reads fail
  sel_ecc_mask u_mask (
    .clock       (clock),
    .rstn        (rstn),
    .wr_valid    (mem_wr),
    .chk_in      (mem_chk),
    .mask        (tmask_ff),
    .wr_valid_ff (mem_wr_ff),
    .chk_out_ff  (mem_chk_ff)
  );

endmodule : sel_error_log

// ===== testbench/sel_error_log_assertions.sv
// concurrent checks on the ports of the sram error log block
module sel_assertions (
  // clock and reset
  input wire logic                      clock,
  input wire logic                      rstn,
  // register bus write side
  input wire logic                      s_awvalid,
  input wire logic                      s_awready,
  input wire logic [7:0]                s_awaddr,
  input wire logic                      s_wvalid,
  input wire logic                      s_wready,
  input wire logic [31:0]               s_wdata,
  input wire logic                      s_bvalid,
  input wire logic                      s_bready,
  input wire logic [1:0]                s_bresp,
  // error reports
  input wire logic                      ecc_err,
  input wire logic                      par_err,
  // array write path and status
  input wire logic                      mem_wr,
  input wire logic [sel_pkg::CHK_W-1:0] mem_chk,
  input wire logic                      mem_wr_ff,
  input wire logic [sel_pkg::CHK_W-1:0] mem_chk_ff,
  input wire logic                      par_check_en_ff,
  input wire logic [31:0]               par_cfg_ff,
  input wire logic [3:0]                err_flags_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] aw_ff;
  logic [7:0] wd_ff;
  logic [7:0] mask_ff;
  // shadow of the test mask, taken only once the response is accepted
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_ff   <= 8'h00;
      wd_ff   <= 8'h00;
      mask_ff <= 8'h00;
    end else begin
      if (s_awvalid && s_awready) aw_ff <= s_awaddr;
      if (s_wvalid && s_wready) wd_ff <= s_wdata[7:0];
      if (s_bvalid && s_bready && aw_ff == sel_pkg::OFF_ECC_TEST &&
          s_bresp == sel_pkg::RESP_OKAY) mask_ff <= wd_ff;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wr_delay_a: assert property (mem_wr |=> mem_wr_ff)
    else $error("array write strobe not forwarded");
  // a pending response may carry a new mask, so those cycles are skipped
  chk_mask_a: assert property (mem_wr && !s_bvalid |=>
    mem_chk_ff == ($past(mem_chk) ^ mask_ff))
    else $error("stored check bits differ from masked value");
  ecc_first_a: assert property (ecc_err && !err_flags_ff[0] |=> err_flags_ff[0])
    else $error("first ecc flag not set");
  ecc_multi_a: assert property ($rose(err_flags_ff[1]) |->
    $past(ecc_err && err_flags_ff[0]))
    else $error("multiple ecc flag without cause");
  par_first_a: assert property (par_err && par_check_en_ff && !err_flags_ff[2]
    |=> err_flags_ff[2])
    else $error("first parity flag not set");
  par_off_a: assert property (par_err && !par_check_en_ff && !err_flags_ff[2]
    |=> !err_flags_ff[2])
    else $error("parity logged while checking disabled");
  par_multi_a: assert property (par_err && par_check_en_ff && err_flags_ff[2]
    |=> err_flags_ff[3])
    else $error("multiple parity flag not set");
  flag_clear_a: assert property ($fell(err_flags_ff[0]) || $fell(err_flags_ff[2])
    |-> $rose(s_bvalid))
    else $error("first flag dropped without a write");
  // the enable lands in the same edge that raises the write response
  en_cfg_a: assert property ($rose(s_bvalid) && aw_ff == sel_pkg::OFF_PAR_CSR
    |-> par_check_en_ff == wd_ff[0] && par_cfg_ff[0] == wd_ff[0])
    else $error("parity enable differs from the written bit");
endmodule : sel_assertions

bind sel_error_log sel_assertions sel_assertions_i (.clock, .rstn, .s_awvalid, .s_awready,
  .s_awaddr, .s_wvalid, .s_wready, .s_wdata, .s_bvalid, .s_bready, .s_bresp, .ecc_err,
  .par_err, .mem_wr, .mem_chk, .mem_wr_ff, .mem_chk_ff, .par_check_en_ff, .par_cfg_ff,
  .err_flags_ff);

// ===== testbench/sel_sram_model.sv
// behavioural sram array keeping check bits and reporting ecc mismatches on read
module sel_sram_model (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rstn,
  // stored write from the block and bench reference
  input  wire logic                      mem_wr_ff,
  input  wire logic [sel_pkg::CHK_W-1:0] mem_chk_ff,
  input  wire logic [sel_pkg::CHK_W-1:0] ref_chk,
  input  wire logic [3:0]                addr,
  input  wire logic                      mrd,
  // error report toward the block
  output logic                           ecc_err,
  output logic [sel_pkg::SYN_W-1:0]      ecc_syndrome
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] arr [16];
  logic [7:0] gold [16];
  // keep stored and true check bits, flag a difference on read
  always @(posedge clock) begin
    if (mem_wr_ff) begin
      arr[addr] <= mem_chk_ff;
      gold[addr] <= ref_chk;
    end
    ecc_err <= rstn && mrd && ((arr[addr] ^ gold[addr]) != 8'h00);
    // outside a read the syndrome toggles so a stale value never looks valid
    ecc_syndrome <= mrd ? (arr[addr] ^ gold[addr]) : ~ecc_syndrome;
  end
endmodule : sel_sram_model

// ===== testbench/tb_sel_error_log.sv
// self-checking bench of the sram error log block
module tb_sel_error_log;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, ecc_err, ecc_multi, ecc_is_write;
  logic tb_ecc, mdl_ecc, par_err, mem_wr, mem_wr_ff, par_check_en_ff, mrd;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [3:0] s_wstrb, par_type, err_flags_ff, maddr;
  logic [7:0] s_awaddr, s_araddr, mem_chk, mem_chk_ff, tb_syn, mdl_syn, ecc_syndrome, m;
  logic [31:0] s_wdata, s_rdata, par_cfg_ff, desc_tag, rd_word, lfsr_ff, e;
  logic [35:0] ecc_addr, par_addr, par_ctx_addr;
  int n_errors, checks_done;
  assign ecc_err = tb_ecc | mdl_ecc;
  assign ecc_syndrome = mdl_ecc ? mdl_syn : tb_syn;
  sel_error_log sel_error_log_i (.clock, .rstn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
    .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .ecc_err, .ecc_multi, .ecc_is_write,
    .ecc_syndrome, .ecc_addr, .desc_tag, .par_err, .par_type, .par_addr, .par_ctx_addr,
    .mem_wr, .mem_chk, .mem_wr_ff, .mem_chk_ff, .par_check_en_ff, .par_cfg_ff, .err_flags_ff);
  sel_sram_model sel_sram_model_i (.clock, .rstn, .mem_wr_ff, .mem_chk_ff, .ref_chk(mem_chk),
    .addr(maddr), .mrd, .ecc_err(mdl_ecc), .ecc_syndrome(mdl_syn));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] exp_log(input logic mu, input logic w, input logic [7:0] s);
    return {19'h0, w, 3'h0, mu, s};
  endfunction : exp_log
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    @(posedge clock);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && s_awready) s_awvalid <= 1'b0;
      if (!w_ok && s_wready) s_wvalid <= 1'b0;
      aw_ok = aw_ok || s_awready;
      w_ok = w_ok || s_wready;
    end
    while (!s_bvalid) @(posedge clock);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    do @(posedge clock); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge clock);
    rd_word = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : bus_rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a);
    chk(rd_word, exp);
  endtask : rchk
  // ----------------------------------------------------------------
  // error sources standing in for the checkers
  // ----------------------------------------------------------------
  task automatic ecc_pulse(input logic mu, input logic w);
    @(posedge clock);
    lfsr_ff = lfsr_next(lfsr_ff);
    tb_ecc <= 1'b1;
    ecc_multi <= mu;
    ecc_is_write <= w;
    tb_syn <= lfsr_ff[7:0];
    ecc_addr <= {lfsr_ff[3:0], lfsr_ff};
    desc_tag <= ~lfsr_ff;
    @(posedge clock);
    tb_ecc <= 1'b0;
    tb_syn <= ~tb_syn;
  endtask : ecc_pulse
  task automatic par_pulse();
    @(posedge clock);
    lfsr_ff = lfsr_next(lfsr_ff);
    par_err <= 1'b1;
    par_type <= lfsr_ff[3:0];
    par_addr <= {lfsr_ff[7:4], lfsr_ff};
    par_ctx_addr <= {~lfsr_ff[11:8], ~lfsr_ff};
    @(posedge clock);
    par_err <= 1'b0;
    par_addr <= ~par_addr;
  endtask : par_pulse
  // the address and check bits are held until the model has stored them
  task automatic mem_op(input logic [3:0] a, input logic [7:0] c, input logic r);
    @(posedge clock);
    maddr <= a;
    mem_chk <= c;
    mem_wr <= !r;
    mrd <= r;
    @(posedge clock);
    mem_wr <= 1'b0;
    mrd <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : mem_op
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    final_report();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, tb_ecc, par_err, mem_wr, mrd} = '0;
    {ecc_multi, ecc_is_write, rstn, s_awaddr, s_araddr, s_wdata, tb_syn, mem_chk} = '0;
    {maddr, par_type, ecc_addr, par_addr, par_ctx_addr, desc_tag} = '0;
    s_wstrb = 4'hF;
    lfsr_ff = 32'h1eaa;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      rchk(8'(4 * i), 32'h0);
    end
    bus_rd(8'h2C);
    chk({rd_word[29:0], resp}, {30'h0, sel_pkg::RESP_SLVERR});
    ecc_pulse(1'b0, 1'b0);
    e = lfsr_ff;
    ecc_pulse(1'b1, 1'b1);
    rchk(sel_pkg::OFF_ECC_LOG, exp_log(1'b0, 1'b0, e[7:0]));
    rchk(sel_pkg::OFF_ECC_ADDR, e);
    rchk(sel_pkg::OFF_ECC_CTX, ~e);
    rchk(sel_pkg::OFF_ECC_CTRL, {28'h0, e[3:0]});
    rchk(sel_pkg::OFF_INT_STATUS, 32'h3);
    bus_wr(sel_pkg::OFF_INT_STATUS, 32'h3);
    ecc_pulse(1'b1, 1'b1);
    rchk(sel_pkg::OFF_ECC_LOG, exp_log(1'b1, 1'b1, lfsr_ff[7:0]));
    par_pulse();
    rchk(sel_pkg::OFF_INT_STATUS, 32'h1);
    bus_wr(sel_pkg::OFF_PAR_CSR, 32'h0000_00F1);
    rchk(sel_pkg::OFF_PAR_CSR, 32'h1);
    par_pulse();
    e = lfsr_ff;
    par_pulse();
    rchk(sel_pkg::OFF_PAR_CSR, {24'h0, e[3:0], 4'h1});
    rchk(sel_pkg::OFF_PAR_ADDR_LO, e);
    rchk(sel_pkg::OFF_PAR_ADDR_HI, {28'h0, e[7:4]});
    rchk(sel_pkg::OFF_PAR_CTX_LO, ~e);
    rchk(sel_pkg::OFF_PAR_CTX_HI, {28'h0, ~e[11:8]});
    bus_wr(sel_pkg::OFF_PAR_ADDR_LO, ~e);
    chk({30'h0, resp}, {30'h0, sel_pkg::RESP_OKAY});
    rchk(sel_pkg::OFF_PAR_ADDR_LO, e);
    rchk(sel_pkg::OFF_INT_STATUS, 32'h301);
    bus_wr(sel_pkg::OFF_INT_STATUS, 32'h301);
    m = 8'h01 << lfsr_ff[2:0];
    ecc_multi <= 1'b0;
    ecc_is_write <= 1'b0;
    bus_wr(sel_pkg::OFF_ECC_TEST, {24'h0, m});
    rchk(sel_pkg::OFF_ECC_TEST, {24'h0, m});
    for (int i = 0; i < 20; i++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      mem_op(lfsr_ff[3:0], lfsr_ff[15:8], 1'b0);
    end
    // read back the last written location, an unwritten one holds no check bits
    mem_op(lfsr_ff[3:0], 8'h00, 1'b1);
    rchk(sel_pkg::OFF_ECC_LOG, exp_log(1'b0, 1'b0, m));
    bus_wr(sel_pkg::OFF_ECC_TEST, 32'h0);
    bus_wr(sel_pkg::OFF_INT_STATUS, 32'h1);
    mem_op(4'h5, lfsr_ff[7:0], 1'b0);
    mem_op(4'h5, 8'h00, 1'b1);
    rchk(sel_pkg::OFF_INT_STATUS, 32'h0);
    final_report();
  end
endmodule : tb_sel_error_log
